// >>> rtl/ccps_pkg.sv
// charge cycle power selector: shared constants, field layouts and types
// assumes a 125 MHz core clock and a 32-bit classic wishbone register bus
package ccps_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int    CLK_HZ          = 125_000_000;
   localparam int    DEAD_TIME_US    = 10;
   localparam int    DEAD_CYCLES     = (DEAD_TIME_US * (CLK_HZ / 1_000_000));
   localparam int    SETTLE_MS       = 30;
   localparam longint SETTLE_CYCLES  = (64'(SETTLE_MS) * CLK_HZ) / 1000;
   // slow timers advance on a tick of this period
   localparam int    TICK_S          = 6;
   localparam longint TICK_CYCLES    = 64'(TICK_S) * CLK_HZ;
   localparam int    PRECHARGE_MIN   = 30;
   localparam int    PRECHARGE_TICKS = (PRECHARGE_MIN * 60) / TICK_S;
   // safety scale 1.4 min per nF, held in tenths of a minute
   localparam int    KTTC_DMIN_PER_NF = 14;
   localparam int    TICKS_PER_NF    = (KTTC_DMIN_PER_NF * 6) / TICK_S;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  STATUS_OFS   = 8'h04;
   localparam int          CTRL_CE_BIT  = 0;
   localparam int          CTRL_CAP_LSB = 4;
   localparam int          CAP_W        = 9;
   localparam logic [31:0] CTRL_MASK    = 32'h0000_1FF1;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0640;
   localparam int          ST_CHG_LSB   = 0;
   localparam int          ST_PS_LSB    = 4;
   localparam int          ST_OT_BIT    = 8;
   localparam int          ST_SAFE_BIT  = 9;
   localparam int          ST_FLAGS_LSB = 16;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic batt_low;
      logic fb_above_recharge;
      logic current_below_term;
      logic uvlo;
      logic supply_low_state;
      logic supply_above_sense;
      logic supply_near_sense;
      logic input_overvoltage;
      logic rails_good;
      logic temp_hot;
      logic temp_cool;
      logic thermistor_fault;
      logic timer_pin_low;
      logic timer_pin_ref;
   } ccps_flags_type;

   localparam int FLAGS_W = $bits(ccps_flags_type);

   typedef enum logic [2:0] {
      CHG_IDLE,
      CHG_PRE,
      CHG_FAST,
      CHG_DONE,
      CHG_FAULT
   } ccps_chg_type;

   typedef enum logic [2:0] {
      PS_BAT,
      PS_WAIT,
      PS_DEAD_AC,
      PS_AC,
      PS_DEAD_BAT
   } ccps_ps_type;

endpackage : ccps_pkg

// >>> rtl/ccps_sync.sv
// three-stage synchroniser with agreement filter, one lane per bit
// assumes raw inputs may change at any time relative to clk_i
`timescale 1ns/10ps
module ccps_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // raw and filtered levels
   input  wire logic [W-1:0] raw_i,
   output logic      [W-1:0] stable_o
);
   import ccps_pkg::*;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic st;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               st <= 1'b0;
            end else begin
               s1 <= raw_i[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  st <= s3;
               end
            end
         end
         assign stable_o[g] = st;
      end
   endgenerate

endmodule : ccps_sync

// >>> rtl/ccps_timer.sv
// saturating up-counter compared against a limit
// assumes clear and run come from logic on clk_i
`timescale 1ns/10ps
module ccps_timer #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // control
   input  wire logic         clear_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] limit_i,
   // result
   output logic              expired_o
);
   import ccps_pkg::*;

   logic [W-1:0] count;

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count <= '0;
      end else if (run_i && !expired_o) begin
         count <= count + 1'b1;
      end
   end

   assign expired_o = (count >= limit_i);

endmodule : ccps_timer

// >>> rtl/ccps_top.sv
// charge cycle sequencer and system power selector with wishbone registers
// assumes analog comparator results arrive as asynchronous digital flags
`timescale 1ns/10ps
module ccps_top #(
   parameter logic [31:0] SETTLE_CYC = 32'(ccps_pkg::SETTLE_CYCLES),
   parameter logic [31:0] TICK_CYC   = 32'(ccps_pkg::TICK_CYCLES)
) (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // wishbone slave
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [31:0]              wb_dat_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic                     wb_we_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   output logic                          wb_ack_o,
   output logic      [31:0]              wb_dat_o,
   // comparator and sense flags
   input  wire ccps_pkg::ccps_flags_type flags_i,
   // switch drives and charge control
   output logic                          adapter_switch_drive_o,
   output logic                          battery_switch_drive_o,
   output logic                          charge_on_o,
   output logic                          precharge_sel_o,
   // status pins
   output logic                          fault_o,
   output logic                          done_o
);
   import ccps_pkg::*;

   // ----------------------------------------------------------------
   // flag synchronisers
   // ----------------------------------------------------------------
   logic [FLAGS_W-1:0] f_vec;
   ccps_flags_type     f;

   ccps_sync #(
      .W(FLAGS_W)
   ) u_sync (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .raw_i    (flags_i),
      .stable_o (f_vec)
   );
   assign f = f_vec;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0]      ctrl;
   logic [31:0]      status;
   logic             charge_enable;
   logic [CAP_W-1:0] cap_nf;
   logic             wb_req;
   logic [31:0]      tick_cnt;
   logic             tick;
   logic             die_overtemp;
   logic             sleep;
   logic             supply_bad;
   logic             supply_bad_q;
   logic             resume;
   logic             ce_q;
   logic             ce_toggle;
   logic             pwrup_done;
   logic             run_ok;
   logic             charging;
   logic             term_en;
   logic             term_hit;
   logic             safety_en;
   logic             safety_clr;
   logic             safety_run;
   logic             safety_exp;
   logic             safety_stop;
   logic [15:0]      safety_lim;
   logic             pre_exp;
   logic             new_cycle;
   logic             ps_clr;
   logic             ps_exp;
   logic [31:0]      ps_lim;
   ccps_chg_type     chg;
   ccps_chg_type     next_chg;
   ccps_ps_type      ps;
   ccps_ps_type      next_ps;

   assign charge_enable = ctrl[CTRL_CE_BIT];
   assign cap_nf        = ctrl[CTRL_CAP_LSB +: CAP_W];

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // byte-lane writes; unused bits stay zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
      end else if (wb_req && wb_we_i && (wb_adr_i == CTRL_OFS)) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8] & CTRL_MASK[8*b +: 8];
            end
         end
      end
   end

   // read data is valid while ack is high; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            CTRL_OFS:   wb_dat_o <= ctrl;
            STATUS_OFS: wb_dat_o <= status;
            default:    wb_dat_o <= 32'h0000_0000;
         endcase
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   always_comb begin
      status                             = 32'h0000_0000;
      status[ST_CHG_LSB +: 3]            = chg;
      status[ST_PS_LSB +: 3]             = ps;
      status[ST_OT_BIT]                  = die_overtemp;
      status[ST_SAFE_BIT]                = safety_stop;
      status[ST_FLAGS_LSB +: FLAGS_W]    = f_vec;
   end

   // ----------------------------------------------------------------
   // slow tick for minute-scale timers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
      end else if (tick_cnt >= (TICK_CYC - 32'h0000_0001)) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         tick     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // supply, temperature and enable conditions
   // ----------------------------------------------------------------
   // overtemp with hysteresis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         die_overtemp <= 1'b0;
      end else if (f.temp_hot) begin
         die_overtemp <= 1'b1;
      end else if (f.temp_cool) begin
         die_overtemp <= 1'b0;
      end
   end

   // sleep when battery node above supply
   assign sleep      = !f.supply_above_sense;
   assign supply_bad = f.uvlo || f.supply_low_state || sleep || f.input_overvoltage;
   assign resume     = supply_bad_q && !supply_bad;
   assign ce_toggle  = charge_enable != ce_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ce_q         <= 1'b0;
         supply_bad_q <= 1'b1;
      end else begin
         ce_q         <= charge_enable;
         supply_bad_q <= supply_bad;
      end
   end

   ccps_timer #(
      .W(32)
   ) u_pwrup (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (1'b0),
      .run_i     (1'b1),
      .limit_i   (SETTLE_CYC),
      .expired_o (pwrup_done)
   );

   assign run_ok = charge_enable && !supply_bad && pwrup_done && f.rails_good
                   && !die_overtemp && !f.thermistor_fault;

   // ----------------------------------------------------------------
   // termination and timers
   // ----------------------------------------------------------------
   assign charging  = (chg == CHG_PRE) || (chg == CHG_FAST);
   assign term_en   = !f.timer_pin_low;
   assign term_hit  = term_en && f.fb_above_recharge && f.current_below_term;
   // pin at reference disables safety timer
   assign safety_en = !f.timer_pin_low && !f.timer_pin_ref;
   assign new_cycle = ce_toggle || ((chg == CHG_DONE) && !f.fb_above_recharge);
   assign safety_clr = new_cycle || f.timer_pin_low || resume;
   assign safety_run = tick && charging && safety_en;
   assign safety_lim = 16'(cap_nf * TICKS_PER_NF);
   assign safety_stop = safety_exp && safety_en && charging;

   ccps_timer #(
      .W(16)
   ) u_safety (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (safety_clr),
      .run_i     (safety_run),
      .limit_i   (safety_lim),
      .expired_o (safety_exp)
   );

   ccps_timer #(
      .W(16)
   ) u_pre (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (chg != CHG_PRE),
      .run_i     (tick),
      .limit_i   (16'(PRECHARGE_TICKS)),
      .expired_o (pre_exp)
   );

   // ----------------------------------------------------------------
   // charge cycle state machine
   // ----------------------------------------------------------------
   always_comb begin
      next_chg = chg;
      if (ce_toggle) begin
         next_chg = CHG_IDLE;
      end else begin
         unique case (chg)
            CHG_IDLE: begin
               if (run_ok) begin
                  next_chg = f.batt_low ? CHG_PRE : CHG_FAST;
               end
            end
            CHG_PRE: begin
               if (!run_ok) begin
                  next_chg = CHG_IDLE;
               end else if (safety_stop || pre_exp) begin
                  next_chg = CHG_FAULT;
               end else if (!f.batt_low) begin
                  next_chg = CHG_FAST;
               end
            end
            CHG_FAST: begin
               if (!run_ok) begin
                  next_chg = CHG_IDLE;
               end else if (safety_stop) begin
                  next_chg = CHG_FAULT;
               end else if (term_hit) begin
                  next_chg = CHG_DONE;
               end
            end
            CHG_DONE: begin
               if (!f.fb_above_recharge) begin
                  next_chg = CHG_IDLE;
               end
            end
            CHG_FAULT: begin
               next_chg = CHG_FAULT;
            end
            default: begin
               next_chg = CHG_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chg <= CHG_IDLE;
      end else begin
         chg <= next_chg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         charge_on_o     <= 1'b0;
         precharge_sel_o <= 1'b0;
         fault_o         <= 1'b0;
         done_o          <= 1'b0;
      end else begin
         charge_on_o     <= (next_chg == CHG_PRE) || (next_chg == CHG_FAST);
         precharge_sel_o <= (next_chg == CHG_PRE);
         fault_o         <= (next_chg == CHG_FAULT);
         done_o          <= (next_chg == CHG_DONE);
      end
   end

   // ----------------------------------------------------------------
   // system power selector
   // ----------------------------------------------------------------
   assign ps_clr = (next_ps != ps);
   assign ps_lim = (ps == PS_WAIT) ? SETTLE_CYC : 32'(DEAD_CYCLES);

   ccps_timer #(
      .W(32)
   ) u_ps (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (ps_clr),
      .run_i     (1'b1),
      .limit_i   (ps_lim),
      .expired_o (ps_exp)
   );

   always_comb begin
      next_ps = ps;
      if (f.uvlo) begin
         next_ps = PS_BAT;
      end else begin
         unique case (ps)
            PS_BAT: begin
               if (!sleep && !f.input_overvoltage) begin
                  next_ps = PS_WAIT;
               end
            end
            PS_WAIT: begin
               if (sleep || f.input_overvoltage) begin
                  next_ps = PS_BAT;
               end else if (ps_exp) begin
                  next_ps = PS_DEAD_AC;
               end
            end
            PS_DEAD_AC: begin
               // sleep aborts the move to adapter
               if (sleep || f.input_overvoltage) begin
                  next_ps = PS_DEAD_BAT;
               end else if (ps_exp) begin
                  next_ps = PS_AC;
               end
            end
            PS_AC: begin
               if (f.supply_near_sense || sleep || f.input_overvoltage) begin
                  next_ps = PS_DEAD_BAT;
               end
            end
            PS_DEAD_BAT: begin
               if (ps_exp) begin
                  next_ps = PS_BAT;
               end
            end
            default: begin
               next_ps = PS_BAT;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ps <= PS_BAT;
      end else begin
         ps <= next_ps;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adapter_switch_drive_o <= 1'b0;
         battery_switch_drive_o <= 1'b1;
      end else begin
         adapter_switch_drive_o <= (next_ps == PS_AC);
         battery_switch_drive_o <= (next_ps == PS_BAT) || (next_ps == PS_WAIT);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_precharge_entry: assert property (
      chg == CHG_IDLE && run_ok && f.batt_low && !ce_toggle
      |=> chg == CHG_PRE && precharge_sel_o && charge_on_o)
      else $error("precharge not selected for low battery");

   a_precharge_timeout: assert property (
      chg == CHG_PRE && pre_exp && run_ok && !ce_toggle
      |=> fault_o && !charge_on_o)
      else $error("precharge timeout did not fault");

   a_term_gate: assert property (
      $rose(done_o) |-> $past(term_hit))
      else $error("termination without both conditions");

   a_recharge_restart: assert property (
      chg == CHG_DONE && !f.fb_above_recharge && !ce_toggle
      |=> chg == CHG_IDLE ##1 !done_o)
      else $error("recharge did not restart cycle");

   a_pin_low_hold: assert property (
      chg == CHG_FAST && f.timer_pin_low && run_ok && !ce_toggle
      |=> chg == CHG_FAST)
      else $error("fast charge left while timer pin low");

   a_stop_charging: assert property (
      charging && !run_ok && !ce_toggle |=> chg == CHG_IDLE && !charge_on_o)
      else $error("charging not stopped on disable");

   a_overtemp_hold: assert property (
      die_overtemp && !f.temp_cool |=> die_overtemp)
      else $error("overtemp cleared before hysteresis");

   a_uvlo_switches: assert property (
      f.uvlo |=> battery_switch_drive_o && !adapter_switch_drive_o)
      else $error("lockout did not select battery");

   a_sleep_battery: assert property (
      sleep && (ps == PS_BAT || ps == PS_WAIT)
      |=> battery_switch_drive_o && !adapter_switch_drive_o)
      else $error("battery not connected in sleep");

   a_sleep_no_adapter: assert property (
      sleep |=> !adapter_switch_drive_o)
      else $error("adapter switch on during sleep");

   a_dead_to_bat: assert property (
      ps == PS_DEAD_BAT && ps_exp |=> battery_switch_drive_o && !adapter_switch_drive_o)
      else $error("battery not reconnected after dead time");

   a_dead_to_ac: assert property (
      $fell(battery_switch_drive_o) |-> !adapter_switch_drive_o [*8])
      else $error("adapter switch on inside dead time");

endmodule : ccps_top

// >>> verif/ccps_far_side.sv
// far side stand-in: adapter, battery pack and timer pin seen as comparator flags
// assumes the bench changes its controls just after rising clock edges
`timescale 1ns/10ps
module ccps_far_side (
   // stimulus controls
   input  wire logic                adapter_i,
   input  wire logic                batt_low_i,
   input  wire logic                full_i,
   input  wire logic                timer_low_i,
   input  wire logic                uvlo_i,
   input  wire logic                hot_i,
   // comparator flags
   output ccps_pkg::ccps_flags_type flags_o
);
   import ccps_pkg::*;
   // a full pack shows high feedback and low current together
   always_comb begin
      flags_o                    = '0;
      flags_o.batt_low           = batt_low_i;
      flags_o.fb_above_recharge  = full_i;
      flags_o.current_below_term = full_i;
      flags_o.uvlo               = uvlo_i;
      flags_o.supply_above_sense = adapter_i;
      flags_o.supply_near_sense  = ~adapter_i;
      flags_o.rails_good         = 1'b1;
      flags_o.temp_hot           = hot_i;
      flags_o.temp_cool          = ~hot_i;
      flags_o.timer_pin_low      = timer_low_i;
   end
endmodule : ccps_far_side

// >>> verif/test_charge_cycle_power_selector.sv
// bench: power selector, charge cycle and register checks
// assumes ccps_pkg, the design and ccps_far_side are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_charge_cycle_power_selector;
   import ccps_pkg::*;
   logic           clk_i, rst_i, cyc, we, ad, bl, fu, tl, uv, hot;
   logic           ack, asw, bsw, chg, pre, flt, dn;
   logic [7:0]     adr;
   logic [31:0]    dat, rdat, dato;
   ccps_flags_type fl;
   int             n_errors = 0;
   int             n_compared = 0;

   ccps_top #(.SETTLE_CYC(32'h0000_0014), .TICK_CYC(32'h0000_000A)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .wb_dat_o(dato),
      .flags_i(fl), .adapter_switch_drive_o(asw), .battery_switch_drive_o(bsw),
      .charge_on_o(chg), .precharge_sel_o(pre), .fault_o(flt), .done_o(dn));
   ccps_far_side far_u (.adapter_i(ad), .batt_low_i(bl), .full_i(fu), .timer_low_i(tl),
      .uvlo_i(uv), .hot_i(hot), .flags_o(fl));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // classic single cycle; ack sampled at a rising edge, request released right after it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdat = dato;
      cyc <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
      `CHK("ack drop", 1'b0, ack)
   endtask : bus

   task automatic idle(input int c);
      repeat (c) @(negedge clk_i);
   endtask : idle

   // counts cycles, and cycles with both switches off, until drives reach want
   task automatic move(input logic [1:0] want, output int n, output int off);
      n = 0;
      off = 0;
      while ({asw, bsw} !== want && n < 3000) begin
         @(negedge clk_i);
         n++;
         off += int'({asw, bsw} === 2'b00);
      end
   endtask : move

   task automatic t_reset();
      idle(1);
      `CHK("drives", 2'b01, {asw, bsw})
      `CHK("stat", 3'b000, {chg, flt, dn})
      bus(1'b0, 8'h00, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0640, rdat)
      bus(1'b0, 8'h10, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rdat)
   endtask : t_reset

   task automatic t_to_adapter();
      int n, off;
      @(posedge clk_i);
      ad <= 1'b1;
      move(2'b10, n, off);
      `CHK("dead", 1'b1, off >= DEAD_CYCLES)
      `CHK("settle", 1'b1, n - off >= 20)
      `CHK("ac on", 2'b10, {asw, bsw})
   endtask : t_to_adapter

   task automatic t_precharge();
      @(posedge clk_i);
      bl <= 1'b1;
      // let the low flag pass the synchroniser before the enable toggle
      idle(8);
      bus(1'b1, 8'h00, 32'h0000_0641);
      idle(12);
      `CHK("pre", 2'b11, {chg, pre})
      bus(1'b0, 8'h04, 32'h0000_0000);
      `CHK("state", 3'h1, rdat[2:0])
      idle(2880);
      `CHK("still", 2'b10, {chg, flt})
      idle(200);
      `CHK("timeout", 2'b01, {chg, flt})
   endtask : t_precharge

   task automatic t_restart(input logic low_pin);
      @(posedge clk_i);
      bl <= 1'b0;
      fu <= 1'b1;
      tl <= low_pin;
      bus(1'b1, 8'h00, 32'h0000_0640);
      bus(1'b1, 8'h00, 32'h0000_0641);
      idle(40);
      `CHK("fault clr", 1'b0, flt)
      `CHK("done", ~low_pin, dn)
      `CHK("chg", low_pin, chg)
   endtask : t_restart

   task automatic t_remove();
      int n, off;
      @(posedge clk_i);
      ad <= 1'b0;
      move(2'b01, n, off);
      `CHK("dead back", 1'b1, off >= DEAD_CYCLES)
      `CHK("sleep chg", 1'b0, chg)
   endtask : t_remove

   task automatic t_uvlo();
      t_to_adapter();
      @(posedge clk_i);
      hot <= 1'b1;
      idle(10);
      `CHK("hot stop", 1'b0, chg)
      bus(1'b0, 8'h04, 32'h0000_0000);
      `CHK("hot flag", 1'b1, rdat[8])
      @(posedge clk_i);
      hot <= 1'b0;
      idle(10);
      `CHK("cool run", 1'b1, chg)
      @(posedge clk_i);
      uv <= 1'b1;
      idle(10);
      `CHK("uvlo", 3'b010, {asw, bsw, chg})
   endtask : t_uvlo

   task automatic report_and_stop();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   initial begin
      {cyc, we, ad, bl, fu, tl, uv, hot} = '0;
      adr = '0;
      dat = '0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_to_adapter();
      t_precharge();
      t_restart(1'b0);
      t_restart(1'b1);
      t_remove();
      t_uvlo();
      report_and_stop();
   end

   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
endmodule : test_charge_cycle_power_selector
